//--- src/xzc_map.svh
`ifndef XZC_MAP_SVH
`define XZC_MAP_SVH
// ==========================================
// Register indices (byte address is four times the index)
`define XZC_IDX_BASE_HIGH 8'hf9
`define XZC_IDX_BASE_LOW 8'hfa
`define XZC_IDX_WIN_SIZE 8'hfb
`define XZC_IDX_IRQ_ROUTE 8'hfc
`define XZC_IDX_ZONE_CTRL 8'hfd
// ==========================================
// Reset values
`define XZC_RST_BASE_HIGH 8'h00
`define XZC_RST_BASE_LOW 8'h00
`define XZC_RST_WIN_SIZE 4'h0
`define XZC_RST_IRQ_ROUTE 4'h0
`define XZC_RST_ZONE_CTRL 2'h0
// ==========================================
// Field layout and limits
`define XZC_SIZE_MAX 4'h8
`define XZC_ZONE_EN_BIT 0
`define XZC_DUAL_EN_BIT 1
`define XZC_MIN_SHIFT 16
`endif

//--- src/xzc_pkg.sv
package xzc_pkg;
	typedef enum logic [1:0] {
		XZC_IDLE = 2'b01,
		XZC_ACCESS = 2'b10
	} xzc_state_t;

	typedef struct packed {
		xzc_state_t st;
		logic pready;
		logic [31:0] prdata;
		logic [7:0] base_high;
		logic [7:0] base_low;
		logic [3:0] win_size;
		logic [3:0] irq_sel;
		logic zone_en;
		logic dual_en;
		logic hit0;
		logic hit1;
		logic [15:1] host_irq;
		logic irq_s1;
		logic irq_s2;
	} xzc_regs_t;
endpackage : xzc_pkg

//--- src/xzc_top.sv
// Overview of operation
// RL1 - High base register supplies zone base address bits 31 to 24.
// RL2 - Low base register supplies zone base address bits 23 to 16.
// RL3 - Base bits 15 to 0 are zero; base sits on 64 Kbyte boundary.
// RL4 - Reset clears base high, base low and size registers to zero.
// RL5 - Software keeps base a whole multiple of the selected zone size.
// RL6 - Size field n gives a window of 2 to the (n+16) bytes.
// RL7 - Size zero is 64 Kbytes and reset value; codes above 16 Mbytes reserved.
// RL8 - Four-bit routing field picks the host IRQ driven by the extension interrupt.
// RL9 - Routing zero disables; values 1 to 15 drive host IRQ 1 to 15.
// RL10 - Dual-zone enable decodes a second equal zone directly above the first.
// RL11 - Cycle hits an enabled zone when bits 31 down to size exponent match.
`timescale 1ns/100ps
`include "xzc_map.svh"

module xzc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic [31:0] host_mem_addr,
	input wire logic ext_bus_irq_in,
	output logic zone0_hit,
	output logic zone1_hit,
	output logic [15:1] host_irq
);
	xzc_pkg::xzc_regs_t r_q;
	xzc_pkg::xzc_regs_t r_d;
	logic [9:0] idx;
	logic wr_go;
	logic rd_go;
	logic unmapped;
	logic [31:0] rd_val;
	logic [4:0] shift;
	logic [31:0] base_full;
	logic [31:0] mask;
	logic [31:0] base1;

	assign idx = paddr[11:2];
	assign shift = 5'(`XZC_MIN_SHIFT) + {1'b0, r_q.win_size}; // see RL6
	// Bits below the window are ignored; base bits 15..0 fixed zero
	assign base_full = {r_q.base_high, r_q.base_low, 16'h0000}; // see RL1 see RL2 see RL3
	assign mask = 32'hffff_ffff << shift;
	assign base1 = base_full + (32'h0000_0001 << shift); // see RL10

	always_comb begin
		unmapped = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (idx)
			{2'b00, `XZC_IDX_BASE_HIGH}: begin
				unmapped = 1'b0;
				rd_val = {24'h0, r_q.base_high};
			end
			{2'b00, `XZC_IDX_BASE_LOW}: begin
				unmapped = 1'b0;
				rd_val = {24'h0, r_q.base_low};
			end
			{2'b00, `XZC_IDX_WIN_SIZE}: begin
				unmapped = 1'b0;
				rd_val = {28'h0, r_q.win_size};
			end
			{2'b00, `XZC_IDX_IRQ_ROUTE}: begin
				unmapped = 1'b0;
				rd_val = {28'h0, r_q.irq_sel};
			end
			{2'b00, `XZC_IDX_ZONE_CTRL}: begin
				unmapped = 1'b0;
				rd_val = {30'h0, r_q.dual_en, r_q.zone_en};
			end
			default: begin
				unmapped = 1'b1;
				rd_val = 32'h0000_0000;
			end
		endcase
	end

	assign wr_go = psel & penable & pwrite & pstrb[0] & ~unmapped;
	assign rd_go = psel & ~penable & ~pwrite;

	always_comb begin
		r_d = r_q;
		r_d.pready = 1'b0;
		// Two-flop synchroniser; only irq_s2 is read by logic
		r_d.irq_s1 = ext_bus_irq_in;
		r_d.irq_s2 = r_q.irq_s1;
		unique case (r_q.st)
			xzc_pkg::XZC_IDLE: begin
				if (psel & ~penable) begin
					r_d.st = xzc_pkg::XZC_ACCESS;
					r_d.pready = 1'b1;
					if (rd_go) begin
						r_d.prdata = rd_val;
					end
				end
			end
			xzc_pkg::XZC_ACCESS: begin
				r_d.st = xzc_pkg::XZC_IDLE;
				if (wr_go) begin
					unique case (idx)
						{2'b00, `XZC_IDX_BASE_HIGH}: r_d.base_high = pwdata[7:0]; // see RL1
						{2'b00, `XZC_IDX_BASE_LOW}: r_d.base_low = pwdata[7:0]; // see RL2
						{2'b00, `XZC_IDX_WIN_SIZE}: begin
							// Reserved codes are refused; the old size stays
							if (pwdata[3:0] <= `XZC_SIZE_MAX) begin
								r_d.win_size = pwdata[3:0]; // see RL7
							end
						end
						{2'b00, `XZC_IDX_IRQ_ROUTE}: r_d.irq_sel = pwdata[3:0]; // see RL8
						{2'b00, `XZC_IDX_ZONE_CTRL}: begin
							r_d.zone_en = pwdata[`XZC_ZONE_EN_BIT];
							r_d.dual_en = pwdata[`XZC_DUAL_EN_BIT];
						end
						default: begin
						end
					endcase
				end
			end
			default: r_d.st = xzc_pkg::XZC_IDLE;
		endcase
		// Misaligned bases are software's duty; low bits are masked out here
		r_d.hit0 = r_q.zone_en & ((host_mem_addr & mask) == (base_full & mask)); // see RL11 see RL5
		r_d.hit1 = r_q.zone_en & r_q.dual_en
			& ((host_mem_addr & mask) == (base1 & mask)); // see RL10 see RL11
		r_d.host_irq = '0;
		if (r_q.irq_sel != 4'h0) begin
			r_d.host_irq[r_q.irq_sel] = r_q.irq_s2; // see RL9
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q.st <= xzc_pkg::XZC_IDLE;
			r_q.pready <= 1'b0;
			r_q.prdata <= 32'h0000_0000;
			r_q.base_high <= `XZC_RST_BASE_HIGH; // see RL4
			r_q.base_low <= `XZC_RST_BASE_LOW;
			r_q.win_size <= `XZC_RST_WIN_SIZE;
			r_q.irq_sel <= `XZC_RST_IRQ_ROUTE; // see RL9
			r_q.zone_en <= 1'b0;
			r_q.dual_en <= 1'b0;
			r_q.hit0 <= 1'b0;
			r_q.hit1 <= 1'b0;
			r_q.host_irq <= 15'h0000;
			r_q.irq_s1 <= 1'b0;
			r_q.irq_s2 <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	assign pready = r_q.pready;
	assign prdata = r_q.prdata;
	assign pslverr = 1'b0;
	assign zone0_hit = r_q.hit0;
	assign zone1_hit = r_q.hit1;
	assign host_irq = r_q.host_irq;

	// ==========================================
	// Checks
	reset_clear_a: assert property (@(posedge pclk) $rose(presetn)
		|-> r_q.base_high == 8'h00 && r_q.base_low == 8'h00 && r_q.win_size == 4'h0) // see RL4
		else $error("config not cleared at reset");
	size_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
		r_q.win_size <= 4'h8) // see RL7
		else $error("reserved size code stored");
	irq_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(r_q.irq_sel) == 4'h0 |-> host_irq == 15'h0000) // see RL9
		else $error("irq routed while disabled");
	irq_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		$past(r_q.irq_sel) != 4'h0 |-> host_irq[$past(r_q.irq_sel)] == $past(r_q.irq_s2)) // see RL8
		else $error("irq not on selected line");
	irq_onehot_a: assert property (@(posedge pclk) disable iff (!presetn)
		$countones(host_irq) <= 1) // see RL8
		else $error("several irq lines driven");
	hit_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(r_q.zone_en) |-> !zone0_hit && !zone1_hit) // see RL11
		else $error("hit while zones disabled");
	base_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
		r_q.zone_en && host_mem_addr[31:16] == {r_q.base_high, r_q.base_low}
		&& r_q.win_size == 4'h0 |=> zone0_hit) // see RL1 see RL2 see RL3
		else $error("zone base not decoded");
	dual_only_a: assert property (@(posedge pclk) disable iff (!presetn)
		zone1_hit |-> $past(r_q.dual_en)) // see RL10
		else $error("second zone hit without dual enable");
	dual_above_a: assert property (@(posedge pclk) disable iff (!presetn)
		r_q.zone_en && r_q.dual_en && r_q.win_size == 4'h0
		&& host_mem_addr[31:16] == {r_q.base_high, r_q.base_low} + 16'h0001 |=> zone1_hit) // see RL10
		else $error("second zone not above first");
	size_win_a: assert property (@(posedge pclk) disable iff (!presetn)
		shift == 5'(`XZC_MIN_SHIFT) + {1'b0, r_q.win_size} && shift <= 5'd24) // see RL6
		else $error("window exponent wrong");
	apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !r_q.pready |=> pready ##1 !pready)
		else $error("apb answer not one cycle");

	// ==========================================
	// Check helpers: one flag per register for a write landing at this edge
	logic wr_acc;
	logic wr_hi;
	logic wr_lo;
	logic wr_sz;
	logic wr_rt;
	logic wr_ct;
	assign wr_acc = (r_q.st == xzc_pkg::XZC_ACCESS) & wr_go;
	assign wr_hi = wr_acc & (idx == {2'b00, `XZC_IDX_BASE_HIGH});
	assign wr_lo = wr_acc & (idx == {2'b00, `XZC_IDX_BASE_LOW});
	assign wr_sz = wr_acc & (idx == {2'b00, `XZC_IDX_WIN_SIZE});
	assign wr_rt = wr_acc & (idx == {2'b00, `XZC_IDX_IRQ_ROUTE});
	assign wr_ct = wr_acc & (idx == {2'b00, `XZC_IDX_ZONE_CTRL});

	// ==========================================
	// Register write and hold checks
	// A write lands only at the access edge
	base_high_wr_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL1
		wr_hi |=> r_q.base_high == $past(pwdata[7:0]))
		else $error("base high write lost");
	base_low_wr_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL2
		wr_lo |=> r_q.base_low == $past(pwdata[7:0]))
		else $error("base low write lost");
	// Nothing but its own write may move a base byte
	base_high_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL1
		!wr_hi |=> $stable(r_q.base_high))
		else $error("base high changed without write");
	base_low_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL2
		!wr_lo |=> $stable(r_q.base_low))
		else $error("base low changed without write");
	// The base can only sit on a 64 Kbyte boundary
	base_low_bits_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL3
		base_full[15:0] == 16'h0000)
		else $error("base low bits not zero");
	base_upper_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL1 see RL2
		base_full[31:16] == {r_q.base_high, r_q.base_low})
		else $error("base bytes misplaced");
	// Legal size codes are stored as written
	size_wr_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL6
		wr_sz && pwdata[3:0] <= `XZC_SIZE_MAX |=> r_q.win_size == $past(pwdata[3:0]))
		else $error("size write lost");
	// Reserved codes leave the old window in place
	size_refuse_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL7
		wr_sz && pwdata[3:0] > `XZC_SIZE_MAX |=> $stable(r_q.win_size))
		else $error("reserved size accepted");
	size_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL6
		!wr_sz |=> $stable(r_q.win_size))
		else $error("size changed without write");
	// Largest window is 16 Mbytes, so the top byte always compares
	mask_span_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL7
		mask[15:0] == 16'h0000 && mask[31:24] == 8'hff)
		else $error("window mask out of range");
	irq_wr_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL8
		wr_rt |=> r_q.irq_sel == $past(pwdata[3:0]))
		else $error("routing write lost");
	irq_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL8
		!wr_rt |=> $stable(r_q.irq_sel))
		else $error("routing changed without write");
	ctrl_wr_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL10
		wr_ct |=> r_q.dual_en == $past(pwdata[1]) && r_q.zone_en == $past(pwdata[0]))
		else $error("zone control write lost");
	ctrl_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL10
		!wr_ct |=> $stable(r_q.dual_en) && $stable(r_q.zone_en))
		else $error("zone control changed without write");
	// Writes without lane zero are dropped whole
	strobe_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && !pstrb[0]
		|=> $stable(r_q.base_high) && $stable(r_q.base_low) && $stable(r_q.irq_sel))
		else $error("write without lane zero taken");
	// Writes to an unmapped index touch nothing
	unmapped_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite && unmapped
		|=> $stable(r_q.base_high) && $stable(r_q.base_low) && $stable(r_q.win_size))
		else $error("unmapped write taken");

	// ==========================================
	// Read-back checks
	// Read data is captured from the setup cycle
	rd_high_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL1
		rd_go && r_q.st == xzc_pkg::XZC_IDLE && idx == {2'b00, `XZC_IDX_BASE_HIGH}
		|=> prdata == {24'h000000, $past(r_q.base_high)})
		else $error("base high read wrong");
	rd_low_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL2
		rd_go && r_q.st == xzc_pkg::XZC_IDLE && idx == {2'b00, `XZC_IDX_BASE_LOW}
		|=> prdata == {24'h000000, $past(r_q.base_low)})
		else $error("base low read wrong");
	rd_size_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL6
		rd_go && r_q.st == xzc_pkg::XZC_IDLE && idx == {2'b00, `XZC_IDX_WIN_SIZE}
		|=> prdata == {28'h0000000, $past(r_q.win_size)})
		else $error("size read wrong");
	rd_route_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL8
		rd_go && r_q.st == xzc_pkg::XZC_IDLE && idx == {2'b00, `XZC_IDX_IRQ_ROUTE}
		|=> prdata == {28'h0000000, $past(r_q.irq_sel)})
		else $error("routing read wrong");
	rd_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL10
		rd_go && r_q.st == xzc_pkg::XZC_IDLE && idx == {2'b00, `XZC_IDX_ZONE_CTRL}
		|=> prdata == {30'h00000000, $past(r_q.dual_en), $past(r_q.zone_en)})
		else $error("zone control read wrong");
	// Reserved upper bits always read as zero
	prdata_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		prdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	// The access phase never stretches past one cycle
	access_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		r_q.st == xzc_pkg::XZC_ACCESS |-> pready)
		else $error("access without ready");
	access_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		r_q.st == xzc_pkg::XZC_ACCESS |=> r_q.st == xzc_pkg::XZC_IDLE)
		else $error("access phase stretched");
	idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!psel |=> !pready)
		else $error("ready without request");

	// ==========================================
	// Decode and interrupt checks
	// Compare by shifting, independent of the mask logic above
	hit0_match_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL11
		r_q.zone_en && (host_mem_addr >> shift) == (base_full >> shift) |=> zone0_hit)
		else $error("first zone missed");
	hit0_miss_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL11
		(host_mem_addr >> shift) != (base_full >> shift) |=> !zone0_hit)
		else $error("first zone false hit");
	// Second zone starts one window above the first
	hit1_match_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL10
		r_q.zone_en && r_q.dual_en
		&& (host_mem_addr >> shift) == (base_full >> shift) + 32'h0000_0001 |=> zone1_hit)
		else $error("second zone missed");
	hit1_off_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL10
		r_q.zone_en && !r_q.dual_en |=> !zone1_hit)
		else $error("second zone hit while single");
	irq_sync_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL8
		r_q.irq_s2 == $past(r_q.irq_s1))
		else $error("interrupt synchroniser skipped");
	// Unselected lines stay quiet
	irq_lines_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL9
		r_q.irq_sel != 4'h0
		|=> (host_irq & ~(15'h0001 << ($past(r_q.irq_sel) - 4'h1))) == 15'h0000)
		else $error("unselected irq line driven");
	irq_level_a: assert property (@(posedge pclk) disable iff (!presetn) // see RL9
		r_q.irq_sel != 4'h0 && r_q.irq_s2 |=> host_irq != 15'h0000)
		else $error("routed irq not raised");

	// ==========================================
	// Reset release checks
	reset_route_a: assert property (@(posedge pclk) $rose(presetn) // see RL9
		|-> r_q.irq_sel == 4'h0 && !r_q.zone_en && !r_q.dual_en)
		else $error("routing not cleared at reset");
	reset_out_a: assert property (@(posedge pclk) $rose(presetn) // see RL4
		|-> !pready && host_irq == 15'h0000 && !zone0_hit && !zone1_hit)
		else $error("outputs not quiet at reset");
endmodule : xzc_top

//--- tb/xzc_host_model.sv
`timescale 1ns/100ps
// =====
// Host side: drives cycle addresses and the interrupt just after an edge
module xzc_host_model (
	input wire logic pclk,
	input wire logic [31:0] cyc_addr,
	input wire logic cyc_irq,
	output logic [31:0] host_mem_addr,
	output logic ext_bus_irq_in
);
	always_ff @(posedge pclk) begin
		host_mem_addr <= cyc_addr;
		ext_bus_irq_in <= cyc_irq;
	end
endmodule : xzc_host_model

//--- tb/test_xzc_top.sv
`timescale 1ns/100ps
`include "xzc_map.svh"
module test_xzc_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cyc_irq = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, cyc_addr = '0, rd, hma, base, a, sz_b;
	logic [3:0] pstrb = 4'hf, sz;
	logic ei, pready, pslverr, z0, z1, d;
	logic [15:1] hirq;
	logic [7:0] ix [5] = '{8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd};
	int err_total = 0, n_checks = 0;
	always #2.5 pclk = ~pclk;
	xzc_host_model host (.pclk(pclk), .cyc_addr(cyc_addr), .cyc_irq(cyc_irq),
		.host_mem_addr(hma), .ext_bus_irq_in(ei));
	xzc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(rd), .pslverr(pslverr), .host_mem_addr(hma), .ext_bus_irq_in(ei),
		.zone0_hit(z0), .zone1_hit(z1), .host_irq(hirq));
	function automatic logic [11:0] ad(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction : ad
	function automatic logic hx(input logic [31:0] b, input logic [31:0] x, input logic [3:0] n);
		return (x >> (n + 16)) == (b >> (n + 16));
	endfunction : hx
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Read data lands in a, taken at the edge that sees pready
	task apb(input logic w, input logic [7:0] i, input logic [31:0] dt);
		int k;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= ad(i);
		pwdata <= dt;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		a = rd;
		chk("slverr", 0, pslverr);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
		if (k >= 20) begin
			err_total++;
			wrap_up();
		end
	endtask : apb
	// =====
	// Main sequence
	initial begin
		void'($urandom(4));
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		foreach (ix[i]) begin
			apb(0, ix[i], 0);
			chk("reset", 0, a);
		end
		$display("reset test done");
		for (int c = 0; c < 16; c++) begin
			apb(1, `XZC_IDX_WIN_SIZE, c);
			apb(0, `XZC_IDX_WIN_SIZE, 0);
			chk("size", c > 8 ? 8 : c, a);
		end
		pstrb <= 4'he;
		apb(1, `XZC_IDX_WIN_SIZE, 3);
		pstrb <= 4'hf;
		apb(0, `XZC_IDX_WIN_SIZE, 0);
		chk("lane", 8, a);
		apb(0, 8'h00, 0);
		chk("unmapped", 0, a);
		$display("register test done");
		for (int k = 0; k < 8; k++) begin
			sz = (k == 0) ? 4'h0 : (k == 1) ? 4'h8 : 4'($urandom % 9);
			sz_b = 32'h1 << (sz + 16);
			base = {8'($urandom & 8'h7f), 8'($urandom), 16'h0} & ~(sz_b - 1);
			d = k[0];
			apb(1, `XZC_IDX_BASE_HIGH, base[31:24]);
			apb(1, `XZC_IDX_BASE_LOW, base[23:16]);
			apb(1, `XZC_IDX_WIN_SIZE, sz);
			apb(1, `XZC_IDX_ZONE_CTRL, {d, 1'b1});
			foreach (ix[j]) begin
				a = base + (j == 4 ? -1 : (j / 2 + 1) * sz_b - j % 2);
				if (j == 0) a = base;
				cyc_addr <= a;
				repeat (4) @(posedge pclk);
				chk("zone0", hx(base, a, sz), z0);
				chk("zone1", d & hx(base + sz_b, a, sz), z1);
			end
		end
		apb(1, `XZC_IDX_ZONE_CTRL, 0);
		cyc_addr <= base;
		repeat (4) @(posedge pclk);
		chk("zone off", 0, z0);
		$display("decode test done");
		for (int v = 0; v < 16; v++) begin
			apb(1, `XZC_IDX_IRQ_ROUTE, v);
			cyc_irq <= 1;
			repeat (6) @(posedge pclk);
			chk("irq", v == 0 ? 15'h0 : 15'h1 << (v - 1), hirq);
			cyc_irq <= 0;
			repeat (6) @(posedge pclk);
			chk("irq low", 0, hirq);
		end
		$display("irq test done");
		wrap_up();
	end
endmodule : test_xzc_top
